// [shared/lpmc_defines.vh]
// constants of the bus transceiver mode and register control block
`ifndef LPMC_DEFINES_VH
`define LPMC_DEFINES_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define LPMC_IDX_PORT_DATA     3'h0
`define LPMC_IDX_CONTROL       3'h1
`define LPMC_IDX_FACTORY_RSVD  3'h2
`define LPMC_IDX_SLOPE_MODE    3'h3
`define LPMC_IDX_SPARE_RSVD    3'h4
`define LPMC_IDX_FAULT_STATUS  3'h5
`define LPMC_IDX_IRQ_ENABLE    3'h6
`define LPMC_IDX_IRQ_FLAGS     3'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LPMC_TX_DRIVE_BIT      1
`define LPMC_RX_STATE_BIT      0
`define LPMC_ENABLE_BIT        3
`define LPMC_RECEIVE_ONLY_SELECT_BIT        2
`define LPMC_WAKEUP_BIT        1
`define LPMC_PULLUP_BIT        0
`define LPMC_TO_DISABLE_BIT    7
`define LPMC_TIMEOUT_BIT       7
`define LPMC_OVERCUR_BIT       6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LPMC_RST_PORT_DATA     2'h0
`define LPMC_RST_CONTROL       4'h0
`define LPMC_RST_FACTORY       8'h00
`define LPMC_RST_SLOPE         3'h0
`define LPMC_RST_IRQ           2'h0

// ------------------------------------------------------------
// operating modes
// ------------------------------------------------------------
`define LPMC_MODE_SHUTDOWN     2'h0
`define LPMC_MODE_NORMAL       2'h1
`define LPMC_MODE_RECEIVE_ONLY_SELECT       2'h2
`define LPMC_MODE_STANDBY      2'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LPMC_CLK_MHZ           100
`define LPMC_WUF_TIME_US       150
`define LPMC_WUF_CYC           (`LPMC_WUF_TIME_US * `LPMC_CLK_MHZ)
`define LPMC_DT_TIME_US        16000
`define LPMC_DT_CYC            (`LPMC_DT_TIME_US * `LPMC_CLK_MHZ)
`define LPMC_WU_PULSE_TIME_US  1
`define LPMC_WU_PULSE_CYC      (`LPMC_WU_PULSE_TIME_US * `LPMC_CLK_MHZ)

`endif

// [design/lpmc_wakeup_filter.v]
// glitch-filtered wake-up detector with a stretched wake pulse
`timescale 1ns/1ps
module lpmc_wakeup_filter #(
   parameter FILTER_CYC = 15000,
   parameter PULSE_CYC  = 100,
   parameter CW         = 24
) (
   input  wire pclk,       // module clock
   input  wire presetn,    // async reset, active low
   input  wire armed,      // standby with wake-up enabled
   input  wire bus_level,  // sampled bus, 1 = recessive
   output reg  wake_r      // wake pulse, high for PULSE_CYC cycles
);

   reg [CW-1:0] dom_cnt_r;
   reg [CW-1:0] pulse_cnt_r;
   reg          prev_r;
   wire         long_dom = (dom_cnt_r > FILTER_CYC[CW-1:0]);

   // ------------------------------------------------------------
   // dominant length, then rising edge
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dom_cnt_r   <= {CW{1'b0}};
         pulse_cnt_r <= {CW{1'b0}};
         prev_r      <= 1'b1;
         wake_r      <= 1'b0;
      end else begin
         prev_r <= bus_level;
         if (!armed || bus_level)
            dom_cnt_r <= {CW{1'b0}};
         else if (!long_dom)
            dom_cnt_r <= dom_cnt_r + {{(CW-1){1'b0}}, 1'b1};
         // strictly longer than the filter time, then the edge; see RL5
         if (armed && bus_level && !prev_r && long_dom) begin
            wake_r      <= 1'b1;
            pulse_cnt_r <= PULSE_CYC[CW-1:0];
         end else if (pulse_cnt_r > {{(CW-1){1'b0}}, 1'b1}) begin
            pulse_cnt_r <= pulse_cnt_r - {{(CW-1){1'b0}}, 1'b1};
         end else begin
            pulse_cnt_r <= {CW{1'b0}};
            wake_r      <= 1'b0;
         end
      end
   end

endmodule

// [design/lpmc_dom_timeout.v]
// transmit-input dominant timeout monitor
`timescale 1ns/1ps
module lpmc_dom_timeout #(
   parameter LIMIT_CYC = 1600000,
   parameter CW        = 24
) (
   input  wire pclk,       // module clock
   input  wire presetn,    // async reset, active low
   input  wire active,     // monitor enabled (normal mode, not disabled)
   input  wire tx_level,   // transmit input, 0 = dominant
   output reg  timeout_r   // dominant held too long
);

   reg [CW-1:0] cnt_r;

   // ------------------------------------------------------------
   // counter restarts on any recessive level
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r     <= {CW{1'b0}};
         timeout_r <= 1'b0;
      end else if (!active || tx_level) begin
         cnt_r     <= {CW{1'b0}};
         timeout_r <= 1'b0;
      end else if (cnt_r >= LIMIT_CYC[CW-1:0]) begin
         timeout_r <= 1'b1; // see RL9
      end else begin
         cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
   end

endmodule

// [design/lpmc_top.v]
// bus transceiver mode control, fault handling and register file
//
// What this block does
// RL1: shutdown disables everything incl. wake-up, bus recessive, registers stay accessible
// RL2: normal mode enables transmitter and receiver
// RL3: receive-only mode disables transmitter, receiver fully active
// RL4: standby disables transmitter, receiver low power, may forward wake-ups
// RL5: wake pulse only after dominant longer than filter time, then rising edge
// RL6: serial interface turns the wake pulse into a wake-up interrupt
// RL7: transmit input used only in normal mode, ignored otherwise
// RL8: standby receive output idle except one short pulse on valid wake-up
// RL9: dominant timeout or overcurrent shuts the transmitter down
// RL10: slope setting selects low, medium or fast bit-rate class
// RL11: eight byte-wide registers decoded at base plus byte offsets 0x00 to 0x1C, four bytes apart
// RL12: enable bit set leaves shutdown; clear means shutdown
// RL13: receive-only bit set selects receive-only mode
// RL14: wake-up enable bit enables wake-up detection in standby
// RL15: slope register writes act only in shutdown, else ignored
// RL16: faults set sticky flags; enabled flags raise the interrupt
// RL17: cleared enable forces shutdown; receive-only beats normal
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "lpmc_defines.vh"
module lpmc_top #(
   parameter WUF_CYC   = `LPMC_WUF_CYC,
   parameter DT_CYC    = `LPMC_DT_CYC,
   parameter PULSE_CYC = `LPMC_WU_PULSE_CYC
) (
   input  wire        pclk,             // module clock, 100 MHz
   input  wire        presetn,          // async reset, active low
   input  wire        psel,             // apb select
   input  wire        penable,          // apb enable
   input  wire        pwrite,           // apb direction
   input  wire [7:0]  paddr,            // apb byte address
   input  wire [31:0] pwdata,           // apb write data
   output reg  [31:0] prdata,           // apb read data
   output wire        pready,           // apb ready
   output wire        pslverr,          // apb error, unmapped address
   input  wire        special_mode,     // factory mode, unlocks reserved reg
   input  wire        standby_req,      // chip low-power request
   input  wire        transceiver_tx_input,  // from serial interface, 0 = dominant
   output reg         transceiver_rx_output, // to serial interface
   output wire        tx_drive_bit,     // software transmit level for routing
   input  wire        bus_in,           // sampled bus level, 1 = recessive
   output wire        bus_out,          // bus drive level, always dominant
   output wire        bus_oe,           // high while driving the bus dominant
   input  wire        overcurrent_in,   // current sensor trip
   output wire        strong_pullup_on, // low-ohmic pullup switched in
   output wire [1:0]  slope_sel,        // slope class to the driver
   output wire [1:0]  mode,             // present operating mode
   output wire        irq               // level interrupt
);

   localparam CW = 24;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg       tx_drive_r;
   reg [3:0] control_r;
   reg [7:0] factory_r;
   reg       to_disable_r;
   reg [1:0] slope_r;
   reg [1:0] irq_en_r;
   reg [1:0] irq_flag_r;
   reg [1:0] irq_flag_nxt;
   reg       tx_shut_r;
   reg       oc_prev_r;
   reg       to_prev_r;
   reg [1:0] mode_nxt;

   wire       timeout;
   wire       wake;
   wire       enable_b = control_r[`LPMC_ENABLE_BIT];
   wire       receive_only_select_b = control_r[`LPMC_RECEIVE_ONLY_SELECT_BIT];
   wire       wakeup_b = control_r[`LPMC_WAKEUP_BIT];
   wire       pullup_b = control_r[`LPMC_PULLUP_BIT];

   // ------------------------------------------------------------
   // mode selection
   // ------------------------------------------------------------
   always @* begin
      if (!enable_b)
         mode_nxt = `LPMC_MODE_SHUTDOWN; // see RL12, see RL17
      else if (receive_only_select_b)
         mode_nxt = `LPMC_MODE_RECEIVE_ONLY_SELECT;   // see RL13, see RL17
      else if (standby_req)
         mode_nxt = `LPMC_MODE_STANDBY;
      else
         mode_nxt = `LPMC_MODE_NORMAL;
   end

   assign mode = mode_nxt;

   wire is_normal  = (mode_nxt == `LPMC_MODE_NORMAL);
   wire is_standby = (mode_nxt == `LPMC_MODE_STANDBY);
   wire is_shut    = (mode_nxt == `LPMC_MODE_SHUTDOWN);

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire [2:0] idx    = paddr[4:2];
   wire       mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0); // see RL11
   wire       wr     = psel && penable && pwrite && mapped;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ------------------------------------------------------------
   // transmitter path
   // ------------------------------------------------------------
   // tx input only matters in normal mode, and only while not tripped
   assign bus_oe  = is_normal && !transceiver_tx_input && !tx_shut_r; // see RL2, see RL7
   assign bus_out = 1'b0;

   // dominant timeout watches the input, not the pin, so it runs even when tripped
   lpmc_dom_timeout #(
      .LIMIT_CYC (DT_CYC),
      .CW        (CW)
   ) u_dt (
      .pclk      (pclk),
      .presetn   (presetn),
      .active    (is_normal && !to_disable_r),
      .tx_level  (transceiver_tx_input),
      .timeout_r (timeout)
   );

   // driver stays off until the trip clears and either the input returns recessive or the mode leaves normal
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shut_r <= 1'b0;
         oc_prev_r <= 1'b0;
         to_prev_r <= 1'b0;
      end else begin
         oc_prev_r <= overcurrent_in;
         to_prev_r <= timeout;
         if (timeout || overcurrent_in)
            tx_shut_r <= 1'b1; // see RL9
         else if (transceiver_tx_input || !is_normal)
            tx_shut_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // receiver and wake-up
   // ------------------------------------------------------------
   lpmc_wakeup_filter #(
      .FILTER_CYC (WUF_CYC),
      .PULSE_CYC  (PULSE_CYC),
      .CW         (CW)
   ) u_wuf (
      .pclk      (pclk),
      .presetn   (presetn),
      .armed     (is_standby && wakeup_b), // see RL14, see RL1
      .bus_level (bus_in),
      .wake_r    (wake)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transceiver_rx_output <= 1'b1;
      end else begin
         case (mode_nxt)
            `LPMC_MODE_NORMAL, `LPMC_MODE_RECEIVE_ONLY_SELECT:
               transceiver_rx_output <= bus_in; // see RL2, see RL3
            `LPMC_MODE_STANDBY:
               transceiver_rx_output <= !wake;  // see RL4, see RL8
            default:
               transceiver_rx_output <= 1'b1;   // see RL1
         endcase
      end
   end

   // strong pullup only with the pullup bit set, and never in shutdown or in standby without wake-up
   assign strong_pullup_on = pullup_b && !is_shut && !(is_standby && !wakeup_b);
   assign slope_sel        = slope_r; // see RL10
   assign tx_drive_bit     = tx_drive_r;

   // ------------------------------------------------------------
   // interrupt flags
   // ------------------------------------------------------------
   // a new fault in the clearing cycle keeps its flag
   always @* begin
      irq_flag_nxt = irq_flag_r;
      if (wr && idx == `LPMC_IDX_IRQ_FLAGS) begin
         irq_flag_nxt[1] = irq_flag_r[1] & ~pwdata[`LPMC_TIMEOUT_BIT];
         irq_flag_nxt[0] = irq_flag_r[0] & ~pwdata[`LPMC_OVERCUR_BIT];
      end
      if (timeout && !to_prev_r)
         irq_flag_nxt[1] = 1'b1; // see RL16
      if (overcurrent_in && !oc_prev_r)
         irq_flag_nxt[0] = 1'b1; // see RL16
   end

   assign irq = |(irq_flag_r & irq_en_r); // see RL16

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_drive_r   <= 1'b0;
         control_r    <= `LPMC_RST_CONTROL;
         factory_r    <= `LPMC_RST_FACTORY;
         to_disable_r <= 1'b0;
         slope_r      <= 2'h0;
         irq_en_r     <= `LPMC_RST_IRQ;
         irq_flag_r   <= `LPMC_RST_IRQ;
      end else begin
         irq_flag_r <= irq_flag_nxt;
         if (wr) begin
            if (idx == `LPMC_IDX_PORT_DATA) begin
               tx_drive_r <= pwdata[`LPMC_TX_DRIVE_BIT];
            end else if (idx == `LPMC_IDX_CONTROL) begin
               control_r <= pwdata[3:0]; // see RL1
            end else if (idx == `LPMC_IDX_FACTORY_RSVD) begin
               if (special_mode)
                  factory_r <= pwdata[7:0];
            end else if (idx == `LPMC_IDX_SLOPE_MODE) begin
               // reprogramming slopes mid-frame would distort edges
               if (is_shut) begin
                  to_disable_r <= pwdata[`LPMC_TO_DISABLE_BIT]; // see RL15
                  slope_r      <= pwdata[1:0];                  // see RL15
               end
            end else if (idx == `LPMC_IDX_IRQ_ENABLE) begin
               irq_en_r <= {pwdata[`LPMC_TIMEOUT_BIT], pwdata[`LPMC_OVERCUR_BIT]};
            end
         end
      end
   end

   // ------------------------------------------------------------
   // read data, latched in the setup phase
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= 32'h0000_0000;
         if (!mapped) begin
            prdata <= 32'h0000_0000;
         end else if (idx == `LPMC_IDX_PORT_DATA) begin
            prdata[1:0] <= {tx_drive_r, transceiver_rx_output};
         end else if (idx == `LPMC_IDX_CONTROL) begin
            prdata[3:0] <= control_r;
         end else if (idx == `LPMC_IDX_FACTORY_RSVD) begin
            prdata[7:0] <= factory_r;
         end else if (idx == `LPMC_IDX_SLOPE_MODE) begin
            prdata[7:0] <= {to_disable_r, 5'h00, slope_r};
         end else if (idx == `LPMC_IDX_FAULT_STATUS) begin
            prdata[7:0] <= {timeout, 7'h00};
         end else if (idx == `LPMC_IDX_IRQ_ENABLE) begin
            prdata[7:0] <= {irq_en_r, 6'h00};
         end else if (idx == `LPMC_IDX_IRQ_FLAGS) begin
            prdata[7:0] <= {irq_flag_r, 6'h00};
         end
      end
   end

endmodule

// [tb/lpmc_bus_node.sv]
// bus partner: another node sharing the single bus wire
`timescale 1ns/1ps
module lpmc_bus_node (
   input  wire pclk,      // module clock
   input  wire dut_oe,    // block pulls wire dominant
   output wire bus_level  // wire level, 1 = recessive
);
   reg hold_r;
   initial hold_r = 1'b0;
   // wired-and with pullup: a released wire goes recessive, never stale
   assign bus_level = ~(dut_oe | hold_r);
   // hold the wire dominant for n cycles, short or long
   task dominant(input integer n);
      begin
         @(posedge pclk);
         hold_r <= 1'b1;
         repeat (n) @(posedge pclk);
         hold_r <= 1'b0;
      end
   endtask
endmodule

// [tb/lpmc_top_sva.sv]
// assertion checker for the transceiver mode control block
`timescale 1ns/1ps
module lpmc_top_sva #(
   parameter WUF_CYC   = 20,
   parameter DT_CYC    = 30,
   parameter PULSE_CYC = 4
) (
   input wire       pclk,                  // clock
   input wire       presetn,               // reset, low
   input wire       psel,                  // apb select
   input wire       penable,               // apb enable
   input wire [7:0] paddr,                 // apb address
   input wire       pslverr,               // apb error
   input wire       transceiver_tx_input,  // tx request
   input wire       transceiver_rx_output, // rx out
   input wire       bus_in,                // wire level
   input wire       bus_oe,                // dominant drive
   input wire       overcurrent_in,        // trip
   input wire [1:0] slope_sel,             // slope class
   input wire [1:0] mode,                  // mode
   input wire       irq                    // interrupt
);
   reg [15:0] low_n_r;
   reg [15:0] run_r;
   reg [15:0] dom_n_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   // timeout-disable bit is not visible here, so a_timeout_cut
   // assumes the bench keeps it clear while tx is held low
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_n_r <= 16'h0000;
         run_r   <= 16'h0000;
         dom_n_r <= 16'h0000;
      end else begin
         low_n_r <= bus_in ? 16'h0000 : low_n_r + 16'h0001;
         if (bus_in && low_n_r != 16'h0000)
            run_r <= low_n_r;
         dom_n_r <= (mode == 2'h1 && !transceiver_tx_input) ? dom_n_r + 16'h0001 : 16'h0000;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_shut_no_drive: assert property (mode == 2'h0 |-> !bus_oe)
      else $error("drive seen in shutdown");
   a_oe_cause: assert property (bus_oe |-> mode == 2'h1 && !transceiver_tx_input)
      else $error("drive without normal mode and dominant tx");
   a_rx_follow: assert property (($past(mode) == 2'h1 || $past(mode) == 2'h2)
      |-> transceiver_rx_output == $past(bus_in)) else $error("rx does not follow bus");
   a_shut_rx_idle: assert property ($past(mode) == 2'h0 |-> transceiver_rx_output)
      else $error("rx active in shutdown");
   a_apb_error: assert property (psel && penable
      |-> pslverr == (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0)) else $error("bad slverr");
   a_wake_filter: assert property ($fell(transceiver_rx_output) && $past(mode) == 2'h3
      |-> run_r > WUF_CYC) else $error("wake pulse without long dominant");
   a_wake_len: assert property ($fell(transceiver_rx_output) && $past(mode) == 2'h3
      |-> (!transceiver_rx_output)[*4] ##1 transceiver_rx_output) else $error("wake length");
   a_timeout_cut: assert property (dom_n_r > DT_CYC + 2 |-> !bus_oe)
      else $error("no shutoff after dominant timeout");
   a_overcur_cut: assert property ($rose(overcurrent_in) && mode == 2'h1 |=> !bus_oe)
      else $error("no shutoff after overcurrent");
   a_irq_hold: assert property (irq && !(psel && penable) |=> irq)
      else $error("irq dropped without a write");
   a_slope_lock: assert property (mode != 2'h0 |=> $stable(slope_sel))
      else $error("slope changed outside shutdown");
endmodule
bind lpmc_top lpmc_top_sva #(.WUF_CYC(WUF_CYC), .DT_CYC(DT_CYC), .PULSE_CYC(PULSE_CYC)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .transceiver_tx_input(transceiver_tx_input),
   .transceiver_rx_output(transceiver_rx_output), .bus_in(bus_in), .bus_oe(bus_oe),
   .overcurrent_in(overcurrent_in), .slope_sel(slope_sel), .mode(mode), .irq(irq));

// [tb/testbench.sv]
// self-checking bench for the transceiver mode control block
`timescale 1ns/1ps
module testbench;
   localparam WUF = 20;
   localparam DT  = 30;
   localparam PUL = 4;
   // mode table rows, row 0 in the low bits
   localparam [47:0] CTL = {8'h0c, 8'h08, 8'h0c, 8'h08, 8'h06, 8'h00};
   localparam [5:0]  SRQ = 6'b110000;
   localparam [11:0] MEX = {2'h2, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
   reg         pclk, presetn, psel, penable, pwrite, special_mode, standby_req, tx_in, oc_in;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rdat;
   reg         serr;
   wire [31:0] prdata;
   wire        pready, pslverr, rx_out, tx_bit, bus_in, bus_oe, irq, pu, bout;
   wire [1:0]  slope_sel, mode;
   integer     n_errors, n_tests, i, k;
   lpmc_top #(.WUF_CYC(WUF), .DT_CYC(DT), .PULSE_CYC(PUL)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .special_mode(special_mode), .standby_req(standby_req), .transceiver_tx_input(tx_in),
      .transceiver_rx_output(rx_out), .tx_drive_bit(tx_bit), .bus_in(bus_in), .bus_out(bout),
      .bus_oe(bus_oe), .overcurrent_in(oc_in), .strong_pullup_on(pu), .slope_sel(slope_sel),
      .mode(mode), .irq(irq));
   lpmc_bus_node node (.pclk(pclk), .dut_oe(bus_oe), .bus_level(bus_in));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task xfer(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rdat = prdata;
         serr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         xfer(1'b0, a, 32'h0);
         chk(rdat, e);
      end
   endtask
   task settle;
      begin
         @(posedge pclk);
         #1;
      end
   endtask
   task low_cnt(input integer n, output integer c);
      begin
         c = 0;
         repeat (n) begin
            settle;
            if (rx_out === 1'b0) c = c + 1;
         end
      end
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge pclk);
      n_errors = n_errors + 1;
      stop_test;
   end
   initial begin
      n_errors = 0;
      n_tests = 0;
      {psel, penable, pwrite, special_mode, standby_req, oc_in, presetn} = 7'h00;
      tx_in = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 8; i = i + 1) rd({1'b0, i[2:0], 2'b00}, (i == 0) ? 1 : 0);
      xfer(1'b0, 8'h20, 32'hffff_ffff);
      chk({31'h0, serr}, 32'h1);
      chk(rdat, 32'h0);
      $display("test reset_map done");
      wr(8'h08, 32'ha5);
      rd(8'h08, 32'h00);
      special_mode <= 1'b1;
      wr(8'h08, 32'ha5);
      rd(8'h08, 32'ha5);
      special_mode <= 1'b0;
      wr(8'h10, 32'hff);
      rd(8'h10, 32'h00);
      wr(8'h14, 32'hff);
      rd(8'h14, 32'h00);
      wr(8'h0c, 32'h83);
      rd(8'h0c, 32'h83);
      chk(slope_sel, 32'h3);
      wr(8'h0c, 32'h01);
      wr(8'h00, 32'h02);
      rd(8'h00, 32'h03);
      chk(tx_bit, 32'h1);
      wr(8'h18, 32'hff);
      rd(8'h18, 32'hc0);
      wr(8'h18, 32'h00);
      $display("test access done");
      tx_in <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
         standby_req <= SRQ[i];
         wr(8'h04, CTL[8*i +: 8]);
         settle;
         chk(mode, MEX[2*i +: 2]);
         chk(bus_oe, MEX[2*i +: 2] == 2'h1);
      end
      tx_in <= 1'b1;
      wr(8'h0c, 32'h02);
      rd(8'h0c, 32'h01);
      standby_req <= 1'b0;
      wr(8'h04, 32'h08);
      node.dominant(3);
      $display("test modes done");
      standby_req <= 1'b1;
      wr(8'h04, 32'h0a);
      node.dominant(WUF / 2);
      low_cnt(20, k);
      chk(k, 0);
      node.dominant(WUF + 5);
      low_cnt(20, k);
      chk(k, PUL);
      wr(8'h04, 32'h08);
      node.dominant(WUF + 5);
      low_cnt(20, k);
      chk(k, 0);
      $display("test wakeup done");
      standby_req <= 1'b0;
      wr(8'h18, 32'hc0);
      tx_in <= 1'b0;
      repeat (5) settle;
      chk(bus_oe, 32'h1);
      repeat (DT + 10) settle;
      chk(bus_oe, 32'h0);
      rd(8'h14, 32'h80);
      rd(8'h1c, 32'h80);
      chk(irq, 32'h1);
      tx_in <= 1'b1;
      repeat (2) settle;
      rd(8'h14, 32'h00);
      wr(8'h1c, 32'h80);
      rd(8'h1c, 32'h00);
      chk(irq, 32'h0);
      tx_in <= 1'b0;
      settle;
      oc_in <= 1'b1;
      settle;
      oc_in <= 1'b0;
      settle;
      chk(bus_oe, 32'h0);
      rd(8'h1c, 32'h40);
      chk(irq, 32'h1);
      wr(8'h18, 32'h80);
      settle;
      chk(irq, 32'h0);
      wr(8'h1c, 32'h40);
      rd(8'h1c, 32'h00);
      wr(8'h04, 32'h09);
      settle;
      chk(pu, 32'h1);
      chk(bout, 32'h0);
      wr(8'h04, 32'h00);
      repeat (2) settle;
      chk(pu, 32'h0);
      chk(bus_oe, 32'h0);
      chk(rx_out, 32'h1);
      tx_in <= 1'b1;
      $display("test faults done");
      stop_test;
   end
endmodule
